// ===== src/sfp_ctrl.sv
// Pin-function and register-write controller of a multi-lane serial flash.
// Operation
// - One-byte register write touches status only.
// - Lane 3 never pauses a transfer.
// - Hardware reset only via lane 3.
// - Lane 3 low, deselected, enabled: reset.
// - Legacy commands unsupported; page program in quad.
// - Read dummy cycles are configurable.
// - All-four-lane mode moves nibbles everywhere; code uses two lanes for dual reads and lane 1 for erase status.
// - Erase-status command reports last erase result; code reports zero while the freeze bit is set.
// - Permanent bit locks persistent protection bits.
// - Protection mode freezes one-time configuration bits; code freezes them for write-any only, not write_registers_cmd.
// - Freeze bit protects one-time address space.
// - Quad bit makes write-protect pin lane 2.
// - Single mode: lane0 in, lane1 out.
// - Dual and quad transfers are supported.
// - Protected register writes ignored without error.
// - Lane-3 reset enabled by config2 bit 5.
// - Sample rising edges; drive after falling.
//
// Added by the designer: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module sfp_ctrl (
  // System clock and reset.
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave.
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic [31:0]      dat_o,
  output logic             ack_o,
  // Serial link pins.
  input  wire logic        sck_i,
  input  wire logic        cs_n_i,
  input  wire logic [3:0]  io_i,
  output logic [3:0]       io_o,
  output logic [3:0]       io_oe_n_o,
  // Reset request raised by the lane-3 reset function.
  output logic             hw_reset_o
);
  // Two-flop synchronisers for all pins.
  logic [5:0] pin_s1;     // First stage, read only by the second.
  logic [5:0] pin_s2;     // Second stage.
  logic [5:0] pin_d;      // Delayed copy for edge detection.
  wire  sck_rise = pin_s2[0] & ~pin_d[0];
  wire  sck_fall = ~pin_s2[0] & pin_d[0];
  wire  cs_n     = pin_s2[1];
  wire  cs_fall  = ~pin_s2[1] & pin_d[1];
  wire  [3:0] io = pin_s2[5:2];

  // Synchroniser registers.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_s1 <= 6'h02;
      pin_s2 <= 6'h02;
      pin_d  <= 6'h02;
    end else begin
      pin_s1 <= {io_i, cs_n_i, sck_i};
      pin_s2 <= pin_s1;
      pin_d  <= pin_s2;
    end
  end

  // Software-visible state.
  logic [15:0] ctrl;      // Control register.
  logic [7:0]  sr1;       // Status register 1.
  logic [7:0]  cfg1;      // Configuration register 1.
  logic [7:0]  prot;      // Protection register, bits clear to program.
  logic [7:0]  nop_cnt;   // Count of ignored instructions.
  logic [7:0]  blk_cnt;   // Count of blocked register writes.
  logic [15:0] next_ctrl;
  logic [7:0]  next_sr1, next_cfg1, next_prot, next_nop, next_blk;
  logic [31:0] next_dat;
  logic        next_ack;
  // Sequencer state.
  sfp_pkg::sfp_state_t state, next_state;
  sfp_pkg::sfp_width_t width, next_width;
  logic [7:0] shreg, next_shreg;   // Shift register.
  logic [7:0] op, next_op;         // Current instruction.
  logic [3:0] bitc, next_bitc;     // Bits taken in the current byte.
  logic [2:0] bytec, next_bytec;   // Data bytes taken.
  logic [7:0] tgt, next_tgt;       // Write-any target.
  logic [7:0] b0, next_b0;         // First data byte kept.
  logic [3:0] dummy, next_dummy;   // Dummy cycles remaining.
  logic       rst_arm, next_rst_arm;
  logic [3:0] nx_io_o, nx_oe_n;
  logic       nx_hwrst;
  logic       mem_we;
  logic [2:0] mem_wa;
  logic       mem_rd;
  logic [7:0] mem_all;

  // Erase status memory; the serial side reads, software marks slots.
  sfp_erase_mem u_erase (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .we_i    (mem_we),
    .waddr_i (mem_wa),
    .wdata_i (dat_i[0]),
    .raddr_i (b0[2:0]),
    .rdata_o (mem_rd),
    .all_o   (mem_all)
  );

  // Shift amount per rising edge for a lane width.
  function automatic logic [3:0] step(input sfp_pkg::sfp_width_t w);
    case (w)
      sfp_pkg::SFP_W2: step = 4'h2;
      sfp_pkg::SFP_W4: step = 4'h4;
      default:         step = 4'h1;
    endcase
  endfunction

  // Shift a byte in at the given width; lanes fixed by mode.
  function automatic logic [7:0] shin(input sfp_pkg::sfp_width_t w, input logic [7:0] s,
                                      input logic [3:0] d);
    case (w)
      sfp_pkg::SFP_W2: shin = {s[5:0], d[1:0]};
      sfp_pkg::SFP_W4: shin = {s[3:0], d[3:0]};
      default:         shin = {s[6:0], d[0]};
    endcase
  endfunction

  wire all_four_lane_mode      = ctrl[sfp_pkg::CTRL_QPI];
  wire quad     = cfg1[sfp_pkg::CFG1_QUAD];
  wire frozen   = cfg1[sfp_pkg::CFG1_FREEZE];  // Guards config1 bit 0 against write_registers_cmd only; write-any is guarded by the protection mode.
  wire prot_sel = ~prot[sfp_pkg::PROT_MODE0] | ~prot[sfp_pkg::PROT_MODE1];
  // Write-protect only acts with quad off; lane 2 is data otherwise.
  wire wp_block = ~quad & sr1[sfp_pkg::SR1_SWD] & ~io[2];

  // Next-state logic for sequencer and registers.
  always_comb begin
    next_state = state; next_width = width; next_shreg = shreg; next_op = op;
    next_bitc = bitc; next_bytec = bytec; next_tgt = tgt; next_b0 = b0;
    next_dummy = dummy; next_rst_arm = rst_arm;
    next_ctrl = ctrl; next_sr1 = sr1; next_cfg1 = cfg1; next_prot = prot;
    next_nop = nop_cnt; next_blk = blk_cnt;
    nx_io_o = io_o; nx_oe_n = io_oe_n_o; nx_hwrst = 1'b0;
    next_dat = dat_o; next_ack = 1'b0; mem_we = 1'b0; mem_wa = adr_i[4:2];
    // Lane-3 reset: armed while high, fires on a low with chip select high.
    if (cs_n & ctrl[sfp_pkg::CTRL_RST_EN]) begin
      if (io[3]) begin
        next_rst_arm = 1'b1;
      end else if (rst_arm) begin
        nx_hwrst = 1'b1;
        next_rst_arm = 1'b0;
      end
    end else begin
      next_rst_arm = 1'b0;
    end
    if (cs_n) begin
      // Deselected: release the lanes and end any command.
      nx_oe_n = 4'hF;
      if (state != sfp_pkg::SFP_IDLE) begin
        // A single data byte updates status only; configuration stays.
        if (state == sfp_pkg::SFP_DATA && op == sfp_pkg::OP_WRITE_REGS && !wp_block
            && bytec != 3'h0) begin
          next_sr1 = b0;
          if (bytec > 3'h1) begin
            next_cfg1 = {shreg[7:1], frozen ? cfg1[0] : shreg[0]};
          end
        end
        next_state = sfp_pkg::SFP_IDLE;
      end
    end else if (cs_fall) begin
      next_state = sfp_pkg::SFP_CMD;
      next_width = all_four_lane_mode ? sfp_pkg::SFP_W4 : sfp_pkg::SFP_W1;
      next_bitc = 4'h0; next_bytec = 3'h0;
    end else if (sck_rise) begin
      // Lane 3 is data only in four-lane width: no pause function exists.
      next_shreg = shin(width, shreg, io);
      next_bitc = bitc + step(width);
      if (bitc + step(width) == 4'h8) begin
        next_bitc = 4'h0;
        case (state)
          sfp_pkg::SFP_CMD: begin
            next_op = next_shreg;
            case (next_shreg)
              sfp_pkg::OP_WRITE_REGS, sfp_pkg::OP_WRITE_ANY, sfp_pkg::OP_ERASE_STATUS:
                next_state = sfp_pkg::SFP_DATA;
              sfp_pkg::OP_DUAL_IO_READ: begin
                next_state = sfp_pkg::SFP_SKIP; next_width = sfp_pkg::SFP_W2;
                next_dummy = ctrl[sfp_pkg::CTRL_DUMMY_LSB +: 4];
              end
              sfp_pkg::OP_QUAD_IO_READ: begin
                next_state = sfp_pkg::SFP_SKIP; next_width = sfp_pkg::SFP_W4;
                next_dummy = ctrl[sfp_pkg::CTRL_DUMMY_LSB +: 4];
              end
              sfp_pkg::OP_ENTER_QUAD: begin
                next_ctrl[sfp_pkg::CTRL_QPI] = 1'b1; next_state = sfp_pkg::SFP_SKIP;
              end
              sfp_pkg::OP_EXIT_QUAD: begin
                next_ctrl[sfp_pkg::CTRL_QPI] = 1'b0; next_state = sfp_pkg::SFP_SKIP;
              end
              default: begin
                // Legacy or unknown codes only raise the ignored-instruction count.
                next_nop = nop_cnt + 8'h01; next_state = sfp_pkg::SFP_SKIP;
              end
            endcase
          end
          sfp_pkg::SFP_DATA: begin
            next_bytec = bytec + 3'h1;
            if (bytec == 3'h0) begin
              next_b0 = next_shreg; next_tgt = next_shreg;
            end
            if (op == sfp_pkg::OP_ERASE_STATUS && bytec == 3'h0) begin
              next_state = sfp_pkg::SFP_OUT;
            end else if (op == sfp_pkg::OP_WRITE_REGS && wp_block) begin
              next_blk = blk_cnt + 8'h01;
              next_state = sfp_pkg::SFP_SKIP;
            end else if (op == sfp_pkg::OP_WRITE_ANY && bytec == 3'h1) begin
              next_state = sfp_pkg::SFP_SKIP;
              case (tgt)
                sfp_pkg::WA_STATUS1_NONVOLATILE, sfp_pkg::WA_SR1V: begin
                  if (wp_block) next_blk = blk_cnt + 8'h01;
                  else next_sr1 = next_shreg;
                end
                sfp_pkg::WA_CFG1NV, sfp_pkg::WA_CFG1V: begin
                  if (wp_block) next_blk = blk_cnt + 8'h01;
                  else if (!prot_sel) next_cfg1 = next_shreg;
                  else next_cfg1[sfp_pkg::CFG1_QUAD] = next_shreg[sfp_pkg::CFG1_QUAD];
                end
                sfp_pkg::WA_PROT: begin
                  // Bits only program toward zero; locked once permanent or chosen.
                  if (prot[sfp_pkg::PROT_PERM] && !prot_sel) begin
                    next_prot = prot & next_shreg;
                  end
                end
                default: next_nop = nop_cnt + 8'h01;
              endcase
            end
          end
          default: ;
        endcase
      end
      // Dummy countdown before a read answer.
      if (state == sfp_pkg::SFP_SKIP && dummy != 4'h0) begin
        next_dummy = dummy - 4'h1;
      end
    end else if (sck_fall && state == sfp_pkg::SFP_OUT) begin
      // Erase result, forced to zero while the freeze bit is set, driven on lane 1 after the falling edge.
      nx_io_o = {2'h0, ~frozen & mem_rd, 1'b0};
      nx_oe_n = 4'hD;
    end
    // Wishbone slave: single-cycle answer, gap enforced by ack.
    if (cyc_i && stb_i && !ack_o) begin
      next_ack = 1'b1;
      next_dat = 32'h0000_0000;
      case (adr_i)
        sfp_pkg::ADDR_CTRL: begin
          if (we_i && sel_i[0]) next_ctrl[7:0] = dat_i[7:0];
          if (we_i && sel_i[1]) next_ctrl[15:8] = dat_i[15:8];
          next_dat = {16'h0000, ctrl};
        end
        sfp_pkg::ADDR_STATUS1: next_dat = {24'h000000, sr1};
        sfp_pkg::ADDR_CONFIG1: next_dat = {24'h000000, cfg1};
        sfp_pkg::ADDR_PROT:    next_dat = {24'h000000, prot};
        sfp_pkg::ADDR_EVENT:   next_dat = {blk_cnt, nop_cnt, 7'h00, dummy, state};
        sfp_pkg::ADDR_ERASE: begin
          mem_we = we_i & sel_i[0];
          mem_wa = dat_i[10:8];
          next_dat = {24'h000000, mem_all};
        end
        default: next_dat = 32'h0000_0000;
      endcase
    end
  end

  // State registers.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= sfp_pkg::SFP_IDLE; width <= sfp_pkg::SFP_W1;
      shreg <= 8'h00; op <= 8'h00; bitc <= 4'h0; bytec <= 3'h0;
      tgt <= 8'h00; b0 <= 8'h00; dummy <= 4'h0; rst_arm <= 1'b0;
      ctrl <= sfp_pkg::CTRL_RESET; sr1 <= sfp_pkg::SR1_RESET;
      cfg1 <= sfp_pkg::CFG1_RESET; prot <= sfp_pkg::PROT_RESET;
      nop_cnt <= 8'h00; blk_cnt <= 8'h00;
      io_o <= 4'h0; io_oe_n_o <= 4'hF; hw_reset_o <= 1'b0;
      dat_o <= 32'h0000_0000; ack_o <= 1'b0;
    end else begin
      state <= next_state; width <= next_width;
      shreg <= next_shreg; op <= next_op; bitc <= next_bitc; bytec <= next_bytec;
      tgt <= next_tgt; b0 <= next_b0; dummy <= next_dummy; rst_arm <= next_rst_arm;
      ctrl <= next_ctrl; sr1 <= next_sr1; cfg1 <= next_cfg1; prot <= next_prot;
      nop_cnt <= next_nop; blk_cnt <= next_blk;
      io_o <= nx_io_o; io_oe_n_o <= nx_oe_n; hw_reset_o <= nx_hwrst;
      dat_o <= next_dat; ack_o <= next_ack;
    end
  end

  // Assertions.
  property p_ack_one;
    @(posedge clk_i) disable iff (rst_i) ack_o |=> !ack_o;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack held two cycles");
  property p_reset_pin;
    @(posedge clk_i) disable iff (rst_i)
      hw_reset_o |-> $past(cs_n) && $past(ctrl[sfp_pkg::CTRL_RST_EN]);
  endproperty
  a_reset_pin: assert property (p_reset_pin) else $error("reset without enable");
  property p_no_drive_deselected;
    @(posedge clk_i) disable iff (rst_i) cs_n |=> io_oe_n_o == 4'hF;
  endproperty
  a_no_drive_deselected: assert property (p_no_drive_deselected)
    else $error("lanes driven while deselected");
  property p_lane0_input;
    @(posedge clk_i) disable iff (rst_i) io_oe_n_o[0] && io_oe_n_o[2] && io_oe_n_o[3];
  endproperty
  a_lane0_input: assert property (p_lane0_input) else $error("input lane driven");
  property p_prot_monotone;
    @(posedge clk_i) disable iff (rst_i) (prot & ~$past(prot)) == 8'h00;
  endproperty
  a_prot_monotone: assert property (p_prot_monotone) else $error("protection bit erased");
  property p_blocked;
    @(posedge clk_i) disable iff (rst_i) $rose(blk_cnt[0]) || $fell(blk_cnt[0])
      |-> $stable(sr1);
  endproperty
  a_blocked: assert property (p_blocked) else $error("blocked write changed status");
  property p_nop;
    @(posedge clk_i) disable iff (rst_i) nop_cnt != $past(nop_cnt)
      |-> $stable(sr1) && $stable(cfg1) && $stable(prot);
  endproperty
  a_nop: assert property (p_nop) else $error("ignored code changed state");
  property p_freeze;
    @(posedge clk_i) disable iff (rst_i) $past(frozen) && prot_sel |-> frozen;
  endproperty
  a_freeze: assert property (p_freeze) else $error("frozen bit released");
  c_reset: cover property (@(posedge clk_i) hw_reset_o);
  c_blocked: cover property (@(posedge clk_i) blk_cnt == 8'h01);
  c_erase: cover property (@(posedge clk_i) !io_oe_n_o[1]);
endmodule
`default_nettype wire

// ===== src/sfp_pkg.sv
// Package of constants and types for the serial flash pin-function controller.
package sfp_pkg;

  // Wishbone register byte offsets.
  localparam logic [7:0] ADDR_CTRL    = 8'h00;  // Control: mode, latency, lane-3 reset enable.
  localparam logic [7:0] ADDR_STATUS1 = 8'h04;  // Status register 1 view.
  localparam logic [7:0] ADDR_CONFIG1 = 8'h08;  // Configuration register 1 view.
  localparam logic [7:0] ADDR_PROT    = 8'h0C;  // Advanced sector protection view.
  localparam logic [7:0] ADDR_EVENT   = 8'h10;  // Link state and counters.
  localparam logic [7:0] ADDR_ERASE   = 8'h14;  // Erase status per sector slot.

  // Control register field positions.
  localparam int CTRL_DUMMY_LSB = 0;    // Read latency dummy cycles, four bits.
  localparam int CTRL_RST_EN    = 5;    // config2_volatile bit 5: lane-3 reset enable.
  localparam int CTRL_QPI       = 8;    // All-four-lane mode.

  // Field positions inside the flash registers.
  localparam int CFG1_FREEZE = 0;       // config1_volatile freeze bit.
  localparam int CFG1_QUAD   = 1;       // config1_volatile quad bit.
  localparam int SR1_SWD     = 7;       // status1_nonvolatile status write disable.
  localparam int PROT_PERM   = 6;       // Makes persistent protection permanent.
  localparam int PROT_MODE0  = 1;       // Persistent protection mode select.
  localparam int PROT_MODE1  = 2;       // Password protection mode select.

  // Reset values.
  localparam logic [15:0] CTRL_RESET  = 16'h0008;
  localparam logic [7:0]  SR1_RESET   = 8'h00;
  localparam logic [7:0]  CFG1_RESET  = 8'h00;
  localparam logic [7:0]  PROT_RESET  = 8'hFF;
  localparam logic [7:0]  ERASE_RESET = 8'hFF;

  // Instruction codes handled by the block.
  localparam logic [7:0] OP_WRITE_REGS   = 8'h01;  // write_registers_cmd.
  localparam logic [7:0] OP_WRITE_ANY    = 8'h71;  // write_any_register_cmd.
  localparam logic [7:0] OP_ERASE_STATUS = 8'hD0;  // Erase-status evaluation.
  localparam logic [7:0] OP_ENTER_QUAD   = 8'h35;  // Enter all_four_lane_mode.
  localparam logic [7:0] OP_EXIT_QUAD    = 8'hF5;  // Exit all_four_lane_mode.
  localparam logic [7:0] OP_DUAL_IO_READ = 8'hBB;  // Two lanes after the instruction.
  localparam logic [7:0] OP_QUAD_IO_READ = 8'hEB;  // Four lanes after the instruction.

  // Write-any-register targets.
  localparam logic [7:0] WA_STATUS1_NONVOLATILE  = 8'h00;
  localparam logic [7:0] WA_CFG1NV = 8'h02;
  localparam logic [7:0] WA_SR1V   = 8'h80;
  localparam logic [7:0] WA_CFG1V  = 8'h82;
  localparam logic [7:0] WA_PROT   = 8'h30;

  // Lane widths.
  typedef enum logic [2:0] {
    SFP_W1 = 3'b001,
    SFP_W2 = 3'b010,
    SFP_W4 = 3'b100
  } sfp_width_t;

  // Command sequencer states.
  typedef enum logic [4:0] {
    SFP_IDLE = 5'b00001,
    SFP_CMD  = 5'b00010,
    SFP_DATA = 5'b00100,
    SFP_OUT  = 5'b01000,
    SFP_SKIP = 5'b10000
  } sfp_state_t;

endpackage

// ===== src/sfp_erase_mem.sv
// Small memory of erase-completion flags, one per sector slot.
`timescale 1ns/10ps
`default_nettype none
module sfp_erase_mem (
  // Clock and reset.
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Write port.
  input  wire logic       we_i,
  input  wire logic [2:0] waddr_i,
  input  wire logic       wdata_i,
  // Read port, registered.
  input  wire logic [2:0] raddr_i,
  output logic            rdata_o,
  output logic [7:0]      all_o
);
  logic [7:0] mem;       // One flag per sector slot.
  logic [7:0] next_mem;  // Next flag contents.
  logic       next_rd;   // Next read value.

  // Next contents: a write replaces one flag.
  always_comb begin
    next_mem = mem;
    if (we_i) begin
      next_mem[waddr_i] = wdata_i;
    end
    next_rd = mem[raddr_i];
  end

  // Registers; all slots read as completed after reset.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mem     <= sfp_pkg::ERASE_RESET;
      rdata_o <= 1'b1;
    end else begin
      mem     <= next_mem;
      rdata_o <= next_rd;
    end
  end

  assign all_o = mem;
endmodule
`default_nettype wire

// ===== verif/sfp_host_model.sv
// Behavioural host controller that drives the serial link of the flash block.
`timescale 1ns/10ps
`default_nettype none
module sfp_host_model (
  // Pacing clock.
  input  wire logic       clk_i,
  // Device side of the lanes.
  input  wire logic [3:0] dev_io_i,
  input  wire logic [3:0] dev_oe_n_i,
  // Link pins as the device sees them.
  output logic            sck_o,
  output logic            cs_n_o,
  output logic [3:0]      io_o
);
  logic [3:0] drv_en;    // Lanes the host drives.
  logic [3:0] drv_val;   // Levels the host drives.
  logic [3:0] last;      // Previous wire levels.
  logic       wp_lvl;    // Write-protect level.
  logic       rst_lvl;   // Lane-3 level outside four-lane transfers.
  logic [7:0] rx;        // Bits taken from lane 1.
  logic       rx_driven; // The device drove lane 1 in this frame.

  initial begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    drv_en = 4'hC;
    drv_val = 4'hC;
    wp_lvl = 1'b1;
    rst_lvl = 1'b1;
    last = 4'h0;
    rx = 8'h00;
    rx_driven = 1'b0;
  end

  // Lanes 2 and 3 have pull-ups; lanes 0 and 1 flip when nobody drives them, so stale data fails.
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      if (!dev_oe_n_i[k]) begin
        io_o[k] = dev_io_i[k];
      end else if (drv_en[k]) begin
        io_o[k] = drv_val[k];
      end else begin
        io_o[k] = (k >= 2) ? 1'b1 : ~last[k];
      end
    end
  end

  // Remember the wire for the floating pattern.
  always @(posedge clk_i) begin
    last <= io_o;
  end

  // Sets the levels held on lanes 2 and 3; only called between frames.
  task automatic set_pins(input logic wp, input logic l3);
    @(posedge clk_i);
    wp_lvl <= wp;
    rst_lvl <= l3;
    drv_val[3:2] <= {l3, wp};
  endtask

  // Selects the device; the link clock stays low outside frames.
  task automatic frame_start();
    @(posedge clk_i);
    cs_n_o <= 1'b0;
    rx_driven <= 1'b0;
    repeat (20) @(posedge clk_i);
  endtask

  // Shifts one byte, MSB first, on lane 0 or four lanes; two lanes send only bits 6, 4, 2, 0 on lane 0; data set while the link clock is low.
  task automatic xfer(input logic [7:0] d, input int lanes);
    for (int i = 8 - lanes; i >= 0; i -= lanes) begin
      @(posedge clk_i);
      sck_o <= 1'b0;
      if (lanes == 4) begin
        drv_en <= 4'hF;
        drv_val <= d[i +: 4];
      end else begin
        drv_en <= 4'hD;
        drv_val <= {rst_lvl, wp_lvl, 1'b0, d[i]};
      end
      repeat (20) @(posedge clk_i);
      sck_o <= 1'b1;
      rx <= {rx[6:0], io_o[1]};
      if (!dev_oe_n_i[1]) begin
        rx_driven <= 1'b1;
      end
      repeat (20) @(posedge clk_i);
    end
  endtask

  // Ends the frame and returns lanes 2 and 3 to their held levels.
  task automatic frame_end();
    @(posedge clk_i);
    sck_o <= 1'b0;
    repeat (20) @(posedge clk_i);
    cs_n_o <= 1'b1;
    drv_en <= 4'hC;
    drv_val <= {rst_lvl, wp_lvl, 2'b00};
    repeat (40) @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

// ===== verif/sfp_ctrl_tb.sv
// Self-checking testbench of the serial flash pin-function controller.
`timescale 1ns/10ps
`default_nettype none
module sfp_ctrl_tb;
  logic        clk_i = 1'b0;  // System clock.
  logic        rst_i = 1'b1;  // Synchronous reset.
  logic        cyc_i = 1'b0;  // Wishbone request lines.
  logic        stb_i = 1'b0;
  logic        we_i = 1'b0;
  logic [7:0]  adr_i = 8'h00;
  logic [3:0]  sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o;         // Read data.
  logic        ack_o;         // Acknowledge.
  logic        sck;           // Link clock.
  logic        cs_n;          // Chip select.
  logic [3:0]  io_wire;       // Resolved lanes.
  logic [3:0]  dev_io;        // Device lane values.
  logic [3:0]  dev_oe_n;      // Device lane enables.
  logic        hw_reset;      // Lane-3 reset request.
  int          num_errors = 0;
  int          total_checks = 0;
  int          rst_pulses = 0; // Reset requests seen.

  sfp_ctrl i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .sck_i(sck),
    .cs_n_i(cs_n), .io_i(io_wire), .io_o(dev_io), .io_oe_n_o(dev_oe_n), .hw_reset_o(hw_reset));
  sfp_host_model i_host (.clk_i(clk_i), .dev_io_i(dev_io), .dev_oe_n_i(dev_oe_n),
    .sck_o(sck), .cs_n_o(cs_n), .io_o(io_wire));

  always #2 clk_i = ~clk_i;

  // Counts reset request pulses.
  always @(posedge clk_i) begin
    if (hw_reset === 1'b1) begin
      rst_pulses <= rst_pulses + 1;
    end
  end

  task automatic end_sim();
    if (num_errors == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask

  // One classic cycle; data is taken and the request dropped at the acknowledging edge.
  task automatic wb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= wr;
    adr_i <= a;
    sel_i <= 4'hF;
    dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 100);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
    if (ack_o !== 1'b1) begin
      num_errors++;
      end_sim();
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    check(nm, exp, q);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask

  // Register write command with one or two data bytes.
  task automatic wr_regs(input int n, input logic [7:0] s, input logic [7:0] c);
    i_host.frame_start();
    i_host.xfer(sfp_pkg::OP_WRITE_REGS, 1);
    i_host.xfer(s, 1);
    if (n == 2) begin
      i_host.xfer(c, 1);
    end
    i_host.frame_end();
  endtask

  // Single-lane frame of an instruction and two bytes.
  task automatic cmd3(input logic [7:0] o, input logic [7:0] a, input logic [7:0] b);
    i_host.frame_start();
    i_host.xfer(o, 1);
    i_host.xfer(a, 1);
    i_host.xfer(b, 1);
    i_host.frame_end();
  endtask

  task automatic t_reset_values();
    rd(sfp_pkg::ADDR_CTRL, {16'h0, sfp_pkg::CTRL_RESET}, "ctrl");
    rd(sfp_pkg::ADDR_STATUS1, {24'h0, sfp_pkg::SR1_RESET}, "status1");
    rd(sfp_pkg::ADDR_CONFIG1, {24'h0, sfp_pkg::CFG1_RESET}, "config1");
    rd(sfp_pkg::ADDR_PROT, {24'h0, sfp_pkg::PROT_RESET}, "prot");
    rd(sfp_pkg::ADDR_ERASE, {24'h0, sfp_pkg::ERASE_RESET}, "erase");
    wr(8'h20, 32'hFFFF_FFFF);
    rd(8'h20, 32'h0, "unmapped");
  endtask

  // The quad bit is set first so that a loss of it would show.
  task automatic t_single_byte();
    wr_regs(2, 8'h00, 8'h02);
    rd(sfp_pkg::ADDR_CONFIG1, 32'h02, "config1");
    wr_regs(1, 8'h1C, 8'h00);
    rd(sfp_pkg::ADDR_STATUS1, 32'h1C, "status1");
    rd(sfp_pkg::ADDR_CONFIG1, 32'h02, "config1");
  endtask

  task automatic t_four_lane();
    wr(sfp_pkg::ADDR_CTRL, 32'h0000_0108);
    i_host.frame_start();
    i_host.xfer(sfp_pkg::OP_WRITE_REGS, 4);
    i_host.xfer(8'h30, 4);
    i_host.frame_end();
    wr(sfp_pkg::ADDR_CTRL, 32'h0000_0008);
    rd(sfp_pkg::ADDR_STATUS1, 32'h30, "status1");
  endtask

  task automatic t_write_protect();
    logic [31:0] q;
    i_host.set_pins(1'b0, 1'b1);
    wr_regs(1, 8'h80, 8'h00);
    rd(sfp_pkg::ADDR_STATUS1, 32'h80, "status1");
    i_host.set_pins(1'b1, 1'b1);
    wr_regs(2, 8'h80, 8'h00);
    rd(sfp_pkg::ADDR_CONFIG1, 32'h00, "config1");
    i_host.set_pins(1'b0, 1'b1);
    wr_regs(2, 8'h04, 8'h02);
    rd(sfp_pkg::ADDR_STATUS1, 32'h80, "status1");
    rd(sfp_pkg::ADDR_CONFIG1, 32'h00, "config1");
    wb(1'b0, sfp_pkg::ADDR_EVENT, 32'h0, q);
    check("blocked count", 32'h01, {24'h0, q[31:24]});
    // Lane 3 held low while the reset function is still off.
    i_host.set_pins(1'b1, 1'b0);
    wr_regs(1, 8'h84, 8'h00);
    rd(sfp_pkg::ADDR_STATUS1, 32'h84, "status1");
    i_host.set_pins(1'b1, 1'b1);
  endtask

  // Legacy codes only raise the ignored count; a dual read then uses up four latency cycles.
  task automatic t_legacy();
    logic [31:0] ev;
    logic [7:0] ops [4] = '{8'h3B, 8'h6B, 8'h0D, 8'hBD};
    for (int i = 0; i < 4; i++) begin
      cmd3(ops[i], 8'hFF, 8'hFF);
    end
    i_host.frame_start();
    i_host.xfer(sfp_pkg::OP_DUAL_IO_READ, 1);
    i_host.xfer(8'h00, 2);
    i_host.frame_end();
    rd(sfp_pkg::ADDR_STATUS1, 32'h84, "status1");
    rd(sfp_pkg::ADDR_CONFIG1, 32'h00, "config1");
    ev = {16'h0104, 7'h00, sfp_pkg::CTRL_RESET[3:0] - 4'h4, sfp_pkg::SFP_IDLE};
    rd(sfp_pkg::ADDR_EVENT, ev, "event");
  endtask

  // A chosen protection mode locks the protection bits and one-time config bits.
  task automatic t_protect();
    cmd3(sfp_pkg::OP_WRITE_ANY, sfp_pkg::WA_PROT, 8'hFD);
    rd(sfp_pkg::ADDR_PROT, 32'hFD, "prot");
    cmd3(sfp_pkg::OP_WRITE_ANY, sfp_pkg::WA_CFG1V, 8'h03);
    rd(sfp_pkg::ADDR_CONFIG1, 32'h02, "config1");
    cmd3(sfp_pkg::OP_WRITE_ANY, sfp_pkg::WA_PROT, 8'h00);
    rd(sfp_pkg::ADDR_PROT, 32'hFD, "prot");
  endtask

  task automatic t_erase();
    wr(sfp_pkg::ADDR_ERASE, 32'h0000_0300);
    rd(sfp_pkg::ADDR_ERASE, 32'h0000_00F7, "erase");
    for (int s = 3; s <= 5; s += 2) begin
      cmd3(sfp_pkg::OP_ERASE_STATUS, 8'(s), 8'h00);
      check("lane1 driven", 32'h1, {31'h0, i_host.rx_driven});
      check("erase status", {31'h0, s == 5}, {31'h0, i_host.rx[7]});
    end
  endtask

  task automatic t_reset_pin();
    int n;
    check("reset requests", 32'h0, rst_pulses);
    wr(sfp_pkg::ADDR_CTRL, 32'h0000_0028);
    i_host.set_pins(1'b1, 1'b0);
    n = 0;
    while (rst_pulses == 0 && n < 100) begin
      @(posedge clk_i);
      n++;
    end
    if (rst_pulses == 0) begin
      num_errors++;
      end_sim();
    end
    repeat (20) @(posedge clk_i);
    check("reset requests", 32'h1, rst_pulses);
  endtask

  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset_values();
    t_single_byte();
    t_four_lane();
    t_write_protect();
    t_legacy();
    t_erase();
    t_protect();
    t_reset_pin();
    end_sim();
  end
endmodule
`default_nettype wire
